//--- common/gpo_pkg.sv
// Operation
// (R1) receiver 0 forces port d bit 0 input
// (R2) forced input keeps latch pull-up, gated by disable
// (R3) bit 0 pin-change source 24 forces input enable
// (R4) bit 0 feeds timer3 count, large variant only
// (R5) compare outputs drive bits 7-4; bit 6 captures
// (R6) transmitter forces output, no pull-up, drives data
// (R7) global pull-up disable kills every port pull-up
// (R8) port a at 0x02/0x01/0x00, reset zero
// (R9) port b at 0x05/0x04/0x03, reset zero
// (R10) port c at 0x08/0x07/0x06, reset zero
// (R11) port d latch 0x0b, direction 0x0a, reset zero
// (R12) port d pin levels at 0x09, no reset
// (R13) direction one makes the pin an output
// (R14) pin reads return sampled pin levels
// (R15) no override: drive latch or float/pull up
package gpo_pkg;

  // ==========================================================
  // register map (index; byte address is four times index)
  localparam logic [5:0] GPO_IDX_PIN_A    = 6'h00;
  localparam logic [5:0] GPO_IDX_DIR_A    = 6'h01;
  localparam logic [5:0] GPO_IDX_LATCH_A  = 6'h02;
  localparam logic [5:0] GPO_IDX_PIN_B    = 6'h03;
  localparam logic [5:0] GPO_IDX_DIR_B    = 6'h04;
  localparam logic [5:0] GPO_IDX_LATCH_B  = 6'h05;
  localparam logic [5:0] GPO_IDX_PIN_C    = 6'h06;
  localparam logic [5:0] GPO_IDX_DIR_C    = 6'h07;
  localparam logic [5:0] GPO_IDX_LATCH_C  = 6'h08;
  localparam logic [5:0] GPO_IDX_PIN_D    = 6'h09;
  localparam logic [5:0] GPO_IDX_DIR_D    = 6'h0A;
  localparam logic [5:0] GPO_IDX_LATCH_D  = 6'h0B;
  localparam logic [5:0] GPO_IDX_SYSCTL   = 6'h0C;
  localparam logic [5:0] GPO_REGS_PER_PRT = 6'h03;

  // ==========================================================
  // fields, ports and reset values
  localparam int         GPO_PORTS        = 4;
  localparam int         GPO_PORT_D       = 3;
  localparam int         GPO_PULLOFF_BIT  = 4;
  localparam int         GPO_BIT_RX0      = 0;
  localparam int         GPO_BIT_TX0      = 1;
  localparam int         GPO_BIT_RX1      = 2;
  localparam int         GPO_BIT_TX1      = 3;
  localparam int         GPO_BIT_XCK      = 4;
  localparam int         GPO_BIT_CAPTURE  = 6;
  localparam logic [7:0] GPO_DIR_RST      = 8'h00;
  localparam logic [7:0] GPO_LATCH_RST    = 8'h00;
  localparam logic       GPO_PULLOFF_RST  = 1'b0;

  // register kind within a port group
  typedef enum logic [1:0] {
    GPO_K_PIN   = 2'b00,
    GPO_K_DIR   = 2'b01,
    GPO_K_LATCH = 2'b10,
    GPO_K_CTRL  = 2'b11
  } gpo_kind_e;

  typedef logic [GPO_PORTS-1:0][7:0] gpo_pins_t;

  // decoded register address
  typedef struct packed {
    logic      hit;
    logic [1:0] port;
    gpo_kind_e kind;
  } gpo_dec_s;

  // per-pin override controls for one port
  typedef struct packed {
    logic [7:0] pullup_override_enable;
    logic [7:0] pullup_override_value;
    logic [7:0] direction_override_enable;
    logic [7:0] direction_override_value;
    logic [7:0] pin_value_override_enable;
    logic [7:0] pin_value_override_value;
    logic [7:0] input_enable_override_enable;
    logic [7:0] input_enable_override_value;
  } gpo_ovr_s;

  // resolved pin drive
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpo_drive_s;

  // peripheral controls reaching port d
  typedef struct packed {
    logic       serial0_receiver_on;
    logic       serial1_receiver_on;
    logic       serial0_transmitter_on;
    logic       serial1_transmitter_on;
    logic       serial0_transmit_line;
    logic       serial1_transmit_line;
    logic [3:0] compare_enable;
    logic [3:0] compare_value;
    logic [7:0] pin_change_mask;
    logic       pin_change_group3_enable;
    logic       irq0_enable;
    logic       irq1_enable;
    logic       sleep;
  } gpo_periph_in_s;

  // port d levels handed to peripherals
  typedef struct packed {
    logic       serial0_receive_line;
    logic       serial1_receive_line;
    logic       timer3_count_input;
    logic       timer1_capture_input;
    logic       external_irq0_input;
    logic       external_irq1_input;
    logic       serial1_external_clock;
    logic [7:0] pin_change_d;
  } gpo_periph_out_s;

endpackage

//--- rtl/gpo_ports.sv
`timescale 1ns/10ps
module gpo_ports #(
  parameter bit LARGE_MEM = 1'b1  // variant with the third timer count input
) (
  input  logic                     clk_in,
  input  logic                     reset_in,
  input  logic                     ce_in,
  input  logic [7:0]               avs_address_in,
  input  logic                     avs_read_in,
  input  logic                     avs_write_in,
  input  logic [31:0]              avs_writedata_in,
  input  logic [3:0]               avs_byteenable_in,
  output logic [31:0]              avs_readdata_out,
  output logic                     avs_waitrequest_out,
  input  gpo_pkg::gpo_pins_t       pins_in,
  output gpo_pkg::gpo_pins_t       pins_out,
  output gpo_pkg::gpo_pins_t       pins_oe_out,
  output gpo_pkg::gpo_pins_t       pullup_out,
  input  gpo_pkg::gpo_periph_in_s  periph_in,
  output gpo_pkg::gpo_periph_out_s periph_out
);

  // ==========================================================
  // state
  logic [7:0]               dir_q [gpo_pkg::GPO_PORTS];  // direction bits
  logic [7:0]               latch_q [gpo_pkg::GPO_PORTS]; // output latches
  gpo_pkg::gpo_pins_t       pin_q;          // sampled pin levels
  logic                     pull_off_q;     // global pull-up disable
  logic                     wait_q;         // waitrequest flop
  logic [31:0]              rdata_q;        // read data flop
  gpo_pkg::gpo_pins_t       pins_out_q;     // registered pin values
  gpo_pkg::gpo_pins_t       pins_oe_q;      // registered enables
  gpo_pkg::gpo_pins_t       pullup_q;       // registered pull-ups
  gpo_pkg::gpo_periph_out_s periph_q;       // registered peripheral levels

  // ==========================================================
  // combinational
  gpo_pkg::gpo_dec_s        dec;            // decoded address
  logic                     wr_go;          // write commits this edge
  logic [7:0]               rd_d;           // read mux result
  gpo_pkg::gpo_ovr_s        ovr_d;          // port d overrides
  gpo_pkg::gpo_drive_s      drv [gpo_pkg::GPO_PORTS]; // resolved drive
  logic [7:0]               ie_d;           // port d input enables
  logic [7:0]               pd_lvl;         // port d gated levels

  // ==========================================================
  // functions

  // address decode: index, port group and kind
  function automatic gpo_pkg::gpo_dec_s reg_decode(input logic [7:0] addr);
    gpo_pkg::gpo_dec_s d;
    logic [5:0]        idx;
    idx = addr[7:2];
    d   = '0;
    // port groups of three registers each
    if (idx <= gpo_pkg::GPO_IDX_LATCH_D)
    begin
      d.hit  = 1'b1;
      d.port = 2'(idx / gpo_pkg::GPO_REGS_PER_PRT);
      d.kind = gpo_pkg::gpo_kind_e'(2'(idx % gpo_pkg::GPO_REGS_PER_PRT));
    end
    // system control register
    else if (idx == gpo_pkg::GPO_IDX_SYSCTL)
    begin
      d.hit  = 1'b1;
      d.kind = gpo_pkg::GPO_K_CTRL;
    end
    return d;
  endfunction

  // pin resolution through the override controls
  function automatic gpo_pkg::gpo_drive_s pin_resolve(
    input logic [7:0]        dir,
    input logic [7:0]        latch,
    input logic              pull_off,
    input gpo_pkg::gpo_ovr_s o
  );
    gpo_pkg::gpo_drive_s r;
    logic [7:0]          dd;
    logic [7:0]          pu;
    // direction: override or direction bit [R13]
    dd = (o.direction_override_enable & o.direction_override_value)
       | (~o.direction_override_enable & dir);
    // default pull-up needs input, latch one, no global disable [R7] [R15]
    pu = ~dir & latch & {8{~pull_off}};
    pu = (o.pullup_override_enable & o.pullup_override_value)
       | (~o.pullup_override_enable & pu);
    r.oe  = dd;
    // driven value: override or latch [R15]
    r.out = (o.pin_value_override_enable & o.pin_value_override_value)
          | (~o.pin_value_override_enable & latch);
    r.pu  = pu & ~dd;
    return r;
  endfunction

  // ==========================================================
  // bus decode and read mux
  assign dec   = reg_decode(avs_address_in);
  assign wr_go = avs_write_in & ~wait_q & avs_byteenable_in[0] & dec.hit;

  // read data selection; unmapped reads give zero
  always_comb
  begin
    rd_d = 8'h00;
    if (dec.hit)
    begin
      case (dec.kind)
        // pin levels, port d gated by its input enables [R14] [R12]
        gpo_pkg::GPO_K_PIN:
          rd_d = (32'(dec.port) == gpo_pkg::GPO_PORT_D) ? pd_lvl : pin_q[dec.port];
        gpo_pkg::GPO_K_DIR:   rd_d = dir_q[dec.port];
        gpo_pkg::GPO_K_LATCH: rd_d = latch_q[dec.port];
        gpo_pkg::GPO_K_CTRL:  rd_d[gpo_pkg::GPO_PULLOFF_BIT] = pull_off_q;
        default:              rd_d = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // avalon handshake: one wait cycle, then a one-cycle answer
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    // answer lasts one cycle even when the clock enable drops
    else if (!wait_q)
      wait_q <= 1'b1;
    // new request: answer at the next edge
    else if (ce_in && (avs_read_in || avs_write_in))
    begin
      wait_q <= 1'b0;
      if (avs_read_in)
        rdata_q <= {24'h000000, rd_d};
    end
  end

  // ==========================================================
  // direction and latch registers
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      // all ports reset to inputs, latches zero [R8] [R9] [R10] [R11]
      for (int k = 0; k < gpo_pkg::GPO_PORTS; k++)
      begin
        dir_q[k]   <= gpo_pkg::GPO_DIR_RST;
        latch_q[k] <= gpo_pkg::GPO_LATCH_RST;
      end
    end
    // write commits on the answer edge [R8] [R9] [R10] [R11]
    else if (wr_go)
    begin
      if (dec.kind == gpo_pkg::GPO_K_DIR)
        dir_q[dec.port] <= avs_writedata_in[7:0];
      else if (dec.kind == gpo_pkg::GPO_K_LATCH)
        latch_q[dec.port] <= avs_writedata_in[7:0];
    end
  end

  // ==========================================================
  // system control: global pull-up disable
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      pull_off_q <= gpo_pkg::GPO_PULLOFF_RST;
    else if (wr_go && dec.kind == gpo_pkg::GPO_K_CTRL)
      pull_off_q <= avs_writedata_in[gpo_pkg::GPO_PULLOFF_BIT]; // [R7]
  end

  // ==========================================================
  // pin sampling; pin level registers have no reset value
  always_ff @(posedge clk_in)
  begin
    if (ce_in)
      pin_q <= pins_in; // [R14]
  end

  // ==========================================================
  // port d override controls
  always_comb
  begin
    ovr_d = '0;
    // receiver 0 holds bit 0 as input, pull-up from latch [R1] [R2]
    ovr_d.pullup_override_enable[0]    = periph_in.serial0_receiver_on;
    ovr_d.pullup_override_value[0]     = latch_q[gpo_pkg::GPO_PORT_D][0] & ~pull_off_q;
    ovr_d.direction_override_enable[0] = periph_in.serial0_receiver_on;
    // transmitter 0 owns bit 1: output, no pull-up, data [R6]
    ovr_d.pullup_override_enable[1]    = periph_in.serial0_transmitter_on;
    ovr_d.direction_override_enable[1] = periph_in.serial0_transmitter_on;
    ovr_d.direction_override_value[1]  = 1'b1;
    ovr_d.pin_value_override_enable[1] = periph_in.serial0_transmitter_on;
    ovr_d.pin_value_override_value[1]  = periph_in.serial0_transmit_line;
    // receiver 1 holds bit 2 as input, pull-up from latch [R2]
    ovr_d.pullup_override_enable[2]    = periph_in.serial1_receiver_on;
    ovr_d.pullup_override_value[2]     = latch_q[gpo_pkg::GPO_PORT_D][2] & ~pull_off_q;
    ovr_d.direction_override_enable[2] = periph_in.serial1_receiver_on;
    // transmitter 1 owns bit 3 [R6]
    ovr_d.pullup_override_enable[3]    = periph_in.serial1_transmitter_on;
    ovr_d.direction_override_enable[3] = periph_in.serial1_transmitter_on;
    ovr_d.direction_override_value[3]  = 1'b1;
    ovr_d.pin_value_override_enable[3] = periph_in.serial1_transmitter_on;
    ovr_d.pin_value_override_value[3]  = periph_in.serial1_transmit_line;
    // compare outputs take the value of bits 7..4 only [R5]
    ovr_d.pin_value_override_enable[7:4] = periph_in.compare_enable;
    ovr_d.pin_value_override_value[7:4]  = periph_in.compare_value;
    // pin change sources keep inputs alive [R3]
    ovr_d.input_enable_override_enable =
      periph_in.pin_change_mask & {8{periph_in.pin_change_group3_enable}};
    // external interrupts also keep their inputs alive
    ovr_d.input_enable_override_enable[2] =
      ovr_d.input_enable_override_enable[2] | periph_in.irq0_enable;
    ovr_d.input_enable_override_enable[3] =
      ovr_d.input_enable_override_enable[3] | periph_in.irq1_enable;
    ovr_d.input_enable_override_value = 8'hFF;
  end

  // port d input enable: override, else off in sleep [R3]
  assign ie_d = (ovr_d.input_enable_override_enable & ovr_d.input_enable_override_value)
              | (~ovr_d.input_enable_override_enable & {8{~periph_in.sleep}});
  assign pd_lvl = pin_q[gpo_pkg::GPO_PORT_D] & ie_d;

  // per-port drive; only port d carries overrides here
  always_comb
  begin
    for (int k = 0; k < gpo_pkg::GPO_PORTS; k++)
      drv[k] = pin_resolve(dir_q[k], latch_q[k], pull_off_q,
                           (k == gpo_pkg::GPO_PORT_D) ? ovr_d : '0);
  end

  // ==========================================================
  // registered pin drive
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pins_out_q <= '0;
      pins_oe_q  <= '0;
      pullup_q   <= '0;
    end
    else if (ce_in)
    begin
      for (int k = 0; k < gpo_pkg::GPO_PORTS; k++)
      begin
        pins_out_q[k] <= drv[k].out;
        pins_oe_q[k]  <= drv[k].oe;
        pullup_q[k]   <= drv[k].pu;
      end
    end
  end

  // ==========================================================
  // registered port d levels for the peripherals
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      periph_q <= '0;
    else if (ce_in)
    begin
      periph_q.pin_change_d           <= pd_lvl; // [R3]
      periph_q.serial0_receive_line   <= pd_lvl[gpo_pkg::GPO_BIT_RX0];
      periph_q.serial1_receive_line   <= pd_lvl[gpo_pkg::GPO_BIT_RX1];
      // count input exists only on the large variant [R4]
      periph_q.timer3_count_input     <= pd_lvl[gpo_pkg::GPO_BIT_RX0] & LARGE_MEM;
      periph_q.timer1_capture_input   <= pd_lvl[gpo_pkg::GPO_BIT_CAPTURE]; // [R5]
      periph_q.external_irq0_input    <= pd_lvl[gpo_pkg::GPO_BIT_RX1];
      periph_q.external_irq1_input    <= pd_lvl[gpo_pkg::GPO_BIT_TX1];
      periph_q.serial1_external_clock <= pd_lvl[gpo_pkg::GPO_BIT_XCK];
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign pins_out            = pins_out_q;
  assign pins_oe_out         = pins_oe_q;
  assign pullup_out          = pullup_q;
  assign periph_out          = periph_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  // a fresh request and its one-cycle answer
  sequence s_req_new;
    ce_in && wait_q && (avs_read_in || avs_write_in);
  endsequence
  sequence s_ack_once;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  a_bus_ack_once: assert property (s_req_new |=> s_ack_once)
    else $error("answer not one cycle after request");

  a_rx0_input: assert property ( // [R1]
    ce_in && periph_in.serial0_receiver_on |=> !pins_oe_out[gpo_pkg::GPO_PORT_D][0])
    else $error("receiver pin not input");

  a_rx_pullup_latch: assert property ( // [R2]
    ce_in && periph_in.serial1_receiver_on
    |=> pullup_out[gpo_pkg::GPO_PORT_D][2]
        == $past(latch_q[gpo_pkg::GPO_PORT_D][2] & ~pull_off_q))
    else $error("receiver pull-up not from latch");

  a_pc24_alive: assert property ( // [R3]
    ce_in && periph_in.sleep && periph_in.pin_change_mask[0]
    && periph_in.pin_change_group3_enable
    |=> periph_out.pin_change_d[0] == $past(pin_q[gpo_pkg::GPO_PORT_D][0]))
    else $error("pin change input not forced on");

  a_t3_variant: assert property ( // [R4]
    ce_in |=> periph_out.timer3_count_input == ($past(pd_lvl[0]) & LARGE_MEM))
    else $error("count input wrong for variant");

  a_compare_drive: assert property ( // [R5]
    ce_in && periph_in.compare_enable[3]
    |=> pins_out[gpo_pkg::GPO_PORT_D][7] == $past(periph_in.compare_value[3]))
    else $error("compare value not on pin");

  a_tx_owns_pin: assert property ( // [R6]
    ce_in && periph_in.serial0_transmitter_on
    |=> pins_oe_out[gpo_pkg::GPO_PORT_D][1] && !pullup_out[gpo_pkg::GPO_PORT_D][1]
        && pins_out[gpo_pkg::GPO_PORT_D][1] == $past(periph_in.serial0_transmit_line))
    else $error("transmit pin not owned");

  a_pullup_kill: assert property ( // [R7]
    ce_in && pull_off_q |=> pullup_out == '0)
    else $error("pull-up on while disabled");

  a_wr_latch_a: assert property ( // [R8]
    wr_go && avs_address_in[7:2] == gpo_pkg::GPO_IDX_LATCH_A
    |=> latch_q[0] == $past(avs_writedata_in[7:0]))
    else $error("port a latch write lost");

  a_wr_dir_b: assert property ( // [R9]
    wr_go && avs_address_in[7:2] == gpo_pkg::GPO_IDX_DIR_B
    |=> dir_q[1] == $past(avs_writedata_in[7:0]))
    else $error("port b direction write lost");

  a_rd_latch_c: assert property ( // [R10]
    s_req_new and (avs_read_in && avs_address_in[7:2] == gpo_pkg::GPO_IDX_LATCH_C)
    |=> avs_readdata_out == {24'h000000, $past(latch_q[2])})
    else $error("port c latch read wrong");

  a_wr_dir_d: assert property ( // [R11]
    wr_go && avs_address_in[7:2] == gpo_pkg::GPO_IDX_DIR_D
    |=> dir_q[gpo_pkg::GPO_PORT_D] == $past(avs_writedata_in[7:0]))
    else $error("port d direction write lost");

  a_rd_pins_d: assert property ( // [R12] [R14]
    s_req_new and (avs_read_in && avs_address_in[7:2] == gpo_pkg::GPO_IDX_PIN_D)
    |=> avs_readdata_out == {24'h000000, $past(pd_lvl)})
    else $error("port d pin read wrong");

  a_dir_output: assert property ( // [R13]
    ce_in && dir_q[0][0] |=> pins_oe_out[0][0])
    else $error("direction one not output");

  a_idle_drive: assert property ( // [R15]
    ce_in |=> pins_out[0] == $past(latch_q[0]))
    else $error("port a pin not latch value");

endmodule

//--- sim/gpo_board.sv
`timescale 1ns/10ps
// ==========================================================
// board model: resolves each pin level from device and board drive
module gpo_board (
  input  logic               clk_in,
  input  gpo_pkg::gpo_pins_t pins_out_in,
  input  gpo_pkg::gpo_pins_t pins_oe_in,
  input  gpo_pkg::gpo_pins_t pullup_in,
  input  gpo_pkg::gpo_pins_t ext_en_in,
  input  gpo_pkg::gpo_pins_t ext_val_in,
  output gpo_pkg::gpo_pins_t level_out
);
  gpo_pkg::gpo_pins_t float_q;  // level of an undriven, unpulled pin

  // a floating pin flips every cycle so no stale value survives
  initial float_q = '0;
  always @(posedge clk_in)
  begin
    float_q <= ~float_q;
  end

  // device drive wins, then board drive, then pull-up, else floating
  assign level_out = (pins_oe_in & pins_out_in)
                   | (~pins_oe_in & ext_en_in & ext_val_in)
                   | (~pins_oe_in & ~ext_en_in & (pullup_in | float_q));
endmodule

//--- sim/gpo_ports_tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// testbench: register access, pin drive and port d overrides
module gpo_ports_tb_top;
  logic                     clk_in;            // 25 MHz clock
  logic                     reset_in;          // async reset
  logic [7:0]               avs_address_in;    // byte address
  logic                     avs_read_in;       // read request
  logic                     avs_write_in;      // write request
  logic [31:0]              avs_writedata_in;  // write data
  logic [31:0]              avs_readdata_out;  // read data
  logic                     avs_waitrequest_out;
  gpo_pkg::gpo_pins_t       pins_in;           // resolved pin levels
  gpo_pkg::gpo_pins_t       pins_out;
  gpo_pkg::gpo_pins_t       pins_oe_out;
  gpo_pkg::gpo_pins_t       pullup_out;
  gpo_pkg::gpo_pins_t       ext_en;            // board drives the pin
  gpo_pkg::gpo_pins_t       ext_val;           // board drive level
  gpo_pkg::gpo_periph_in_s  per;               // peripheral controls
  gpo_pkg::gpo_periph_out_s pout;
  int                       err_total;
  int                       tests_run;
  logic [7:0]               rd;                // last read data
  logic [7:0]               dv;                // direction under test
  logic [7:0]               lv;                // latch under test

  // ==========================================================
  // clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  gpo_ports u_gpo_ports (
    .clk_in              (clk_in),
    .reset_in            (reset_in),
    .ce_in               (1'b1),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (4'hF),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .pins_in             (pins_in),
    .pins_out            (pins_out),
    .pins_oe_out         (pins_oe_out),
    .pullup_out          (pullup_out),
    .periph_in           (per),
    .periph_out          (pout)
  );

  gpo_board u_gpo_board (
    .clk_in      (clk_in),
    .pins_out_in (pins_out),
    .pins_oe_in  (pins_oe_out),
    .pullup_in   (pullup_out),
    .ext_en_in   (ext_en),
    .ext_val_in  (ext_val),
    .level_out   (pins_in)
  );

  // ==========================================================
  // compare, bus and closing tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    avs_address_in   <= {idx, 2'b00};
    avs_writedata_in <= {24'h000000, d};
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do
    begin
      @(posedge clk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask

  // pin outputs are registered; periph_out trails by two edges
  task automatic settle;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic test_done;
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clk_in);
    err_total++;
    test_done;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    reset_in = 1'b1;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h00000000;
    per = '0;
    ext_en = '1;
    ext_val = 32'h00C396A5;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    // reset values of every port
    for (int p = 0; p < 4; p++)
    begin
      rdchk("direction reset", 6'(3*p+1), 8'h00);
      rdchk("latch reset", 6'(3*p+2), 8'h00);
    end
    // each port: mixed directions, drive, pull-up and pin read
    for (int p = 0; p < 4; p++)
    begin
      dv = 8'(8'h0F << p);
      lv = 8'h5A ^ 8'(p*17);
      xfer(1'b1, 6'(3*p+1), dv);
      xfer(1'b1, 6'(3*p+2), lv);
      settle;
      rdchk("direction", 6'(3*p+1), dv);
      rdchk("latch", 6'(3*p+2), lv);
      rdchk("pin levels", 6'(3*p), (lv & dv) | (ext_val[p] & ~dv));
      chk("output enable", pins_oe_out[p], dv);
      chk("pin drive", pins_out[p] & dv, lv & dv);
      chk("pull-up", pullup_out[p], lv & ~dv);
    end
    rdchk("unmapped", 6'h0D, 8'h00);
    // global pull-up disable
    xfer(1'b1, gpo_pkg::GPO_IDX_SYSCTL, 8'h10);
    settle;
    chk("pull-up off", pullup_out[0] | pullup_out[1], 8'h00);
    chk("pull-up off", pullup_out[2] | pullup_out[3], 8'h00);
    rdchk("system control", gpo_pkg::GPO_IDX_SYSCTL, 8'h10);
    xfer(1'b1, gpo_pkg::GPO_IDX_SYSCTL, 8'h00);
    // receivers force bits 0 and 2 to input, pull-up from latch
    xfer(1'b1, gpo_pkg::GPO_IDX_DIR_D, 8'hF5);
    xfer(1'b1, gpo_pkg::GPO_IDX_LATCH_D, 8'h0F);
    per.serial0_receiver_on <= 1'b1;
    per.serial1_receiver_on <= 1'b1;
    settle;
    chk("receiver input", pins_oe_out[3] & 8'h05, 8'h00);
    chk("receiver pull-up", pullup_out[3] & 8'h05, 8'h05);
    xfer(1'b1, gpo_pkg::GPO_IDX_SYSCTL, 8'h10);
    settle;
    chk("receiver pull-up off", pullup_out[3] & 8'h05, 8'h00);
    xfer(1'b1, gpo_pkg::GPO_IDX_SYSCTL, 8'h00);
    // transmitters force bits 1 and 3 to drive transmit data
    per.serial0_transmitter_on <= 1'b1;
    per.serial1_transmitter_on <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      per.serial0_transmit_line <= 1'(v);
      per.serial1_transmit_line <= 1'(v);
      settle;
      chk("transmit enable", pins_oe_out[3] & 8'h0A, 8'h0A);
      chk("transmit data", pins_out[3] & 8'h0A, v ? 8'h0A : 8'h00);
      chk("transmit pull-up", pullup_out[3] & 8'h0A, 8'h00);
    end
    // compare outputs take bits 7 to 4, no direction override
    per.compare_enable <= 4'hF;
    per.compare_value <= 4'hA;
    settle;
    chk("compare drive", pins_out[3] & 8'hF0, 8'hA0);
    xfer(1'b1, gpo_pkg::GPO_IDX_DIR_D, 8'h01);
    settle;
    chk("compare direction", pins_oe_out[3] & 8'hF0, 8'h00);
    // pin-change sources and interrupt enables keep inputs alive in sleep
    per.serial1_transmitter_on <= 1'b0;
    per.sleep <= 1'b1;
    per.pin_change_mask <= 8'h51;
    per.pin_change_group3_enable <= 1'b1;
    per.irq0_enable <= 1'b1;
    per.irq1_enable <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      ext_val[3] <= v ? 8'h5D : 8'h00;
      settle;
      chk("pin change 24", 8'(pout.pin_change_d[0]), 8'(v));
      chk("sleep gating", pout.pin_change_d, v ? 8'h5D : 8'h00);
      chk("receive 0", 8'(pout.serial0_receive_line), 8'(v));
      chk("receive 1", 8'(pout.serial1_receive_line), 8'(v));
      chk("irq 0 input", 8'(pout.external_irq0_input), 8'(v));
      chk("irq 1 input", 8'(pout.external_irq1_input), 8'(v));
      chk("external clock", 8'(pout.serial1_external_clock), 8'(v));
      chk("timer3 count", 8'(pout.timer3_count_input), 8'(v));
      chk("capture input", 8'(pout.timer1_capture_input), 8'(v));
    end
    test_done;
  end
endmodule
